/* pkg/mmd_pkg.sv */
`default_nettype none

package mmd_pkg;

  // Direct management register numbers
  localparam logic [4:0] REG_ACCESS_CONTROL = 5'h0D;
  localparam logic [4:0] REG_DATA_PORT = 5'h0E;

  // Access-control field positions
  localparam int FUNC_MSB = 15;
  localparam int FUNC_LSB = 14;
  localparam int DEVNUM_MSB = 4;
  localparam int DEVNUM_LSB = 0;

  // Access functions held in the function field
  localparam logic [1:0] FUNC_ADDRESS = 2'h0;
  localparam logic [1:0] FUNC_DATA = 2'h1;
  localparam logic [1:0] FUNC_DATA_INC_ALL = 2'h2;
  localparam logic [1:0] FUNC_DATA_INC_WRITE = 2'h3;

  // Only device number served by the data port
  localparam logic [4:0] GENERAL_DEVICE_NUMBER = 5'h1F;

  // Values after reset
  localparam logic [15:0] ACCESS_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] EXT_ADDR_RESET = 16'h0000;
  localparam logic [15:0] CLOCK_OUTPUT_CONFIG_RESET = 16'h0C10;

  // Extended register map
  localparam logic [15:0] CLOCK_OUTPUT_CONFIG_ADDR = 16'h0170;
  localparam int CLOCK_OUTPUT_OFF_BIT = 6;
  localparam logic [15:0] EXT_BLOCKED_CONTROL = 16'h000D;
  localparam logic [15:0] EXT_BLOCKED_PORT = 16'h000E;

  // Management frame layout, in bit times
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [4:0] HEADER_LAST_BIT = 5'h0B;
  localparam logic [4:0] TURN_LAST_BIT = 5'h01;
  localparam logic [4:0] DATA_LAST_BIT = 5'h0F;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;

  // One finished management access, handed from link to core
  typedef struct packed {
    logic write;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } mgmt_access_t;

  // Read values published by the core for the link side
  typedef struct packed {
    logic [15:0] access_control;
    logic [15:0] data_port;
  } read_view_t;

endpackage : mmd_pkg

`default_nettype wire

/* sim/mmd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the management pin and the clock output
module mmd_checker #(
  parameter logic [4:0] PHY_ADDRESS = 5'h00 // Address answered
) (
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Reset
  input wire logic mdc, // Management clock
  input wire logic mdio_in, // Resolved data line
  input wire logic mdio_out, // Device data
  input wire logic mdio_oe, // Device drive enable
  input wire logic clk_out, // Clock output pin
  input wire logic clk_out_running // Clock output enabled
);
  // Drive only after start 01 and read code 10
  chk_read_opcode: assert property (
    @(posedge mdc) disable iff (sys_rst) $rose(mdio_oe) |-> !$past(mdio_in, 15)
    && $past(mdio_in, 14) && $past(mdio_in, 13) && !$past(mdio_in, 12))
    else $error("Data pin driven without read header");
  // Drive only for our own address
  chk_read_address: assert property (
    @(posedge mdc) disable iff (sys_rst) $rose(mdio_oe) |-> {$past(mdio_in, 11),
    $past(mdio_in, 10), $past(mdio_in, 9), $past(mdio_in, 8), $past(mdio_in, 7)}
    == PHY_ADDRESS)
    else $error("Data pin driven for another address");
  // Zero turnaround bit, then exactly sixteen data bit times
  chk_turn_data_span: assert property (
    @(posedge mdc) disable iff (sys_rst) $rose(mdio_oe) |-> !mdio_out
    ##1 mdio_oe [*8] ##1 mdio_oe [*8] ##1 !mdio_oe)
    else $error("Read answer has wrong shape");
  // Released pin carries no stale data
  chk_idle_out_low: assert property (
    @(posedge mdc) disable iff (sys_rst) !mdio_oe |-> !mdio_out)
    else $error("Data driven while released");
  // Half-rate clock: a high phase lasts one cycle
  chk_clk_high_one: assert property (
    @(posedge clk) disable iff (sys_rst) $rose(clk_out) |=> !clk_out)
    else $error("Clock output high too long");
  // Low phase lasts one cycle while enabled
  chk_clk_low_one: assert property (
    @(posedge clk) disable iff (sys_rst) $fell(clk_out) |=> clk_out || !clk_out_running)
    else $error("Clock output low too long");
  // Switching off parks the pin low
  chk_clk_parked: assert property (
    @(posedge clk) disable iff (sys_rst) $fell(clk_out_running) |=> !clk_out [*3])
    else $error("Clock output not parked");
  // A stopped clock stays quiet
  chk_stopped_quiet: assert property (
    @(posedge clk) disable iff (sys_rst) !clk_out_running [*2] |-> !clk_out)
    else $error("Clock output toggles while off");
endmodule : mmd_checker
`default_nettype wire

/* sim/mmd_indirect_register_access_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mmd_indirect_register_access_tb;
  localparam logic [4:0] PHY = 5'h03; // Address given to the device
  localparam logic [4:0] CR = mmd_pkg::REG_ACCESS_CONTROL; // Control
  localparam logic [4:0] DP = mmd_pkg::REG_DATA_PORT; // Data port
  logic clk, sys_rst, mdc, sta_oe, sta_o, mdio_out, mdio_oe, clk_out, clk_out_running;
  logic mdio_wire; // Pulled up when nobody drives
  int error_cnt, cmp_count;
  assign mdio_wire = mdio_oe ? mdio_out : (sta_oe ? sta_o : 1'b1);
  mmd_indirect_register_access #(.PHY_ADDRESS(PHY)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .clk_out(clk_out), .clk_out_running(clk_out_running));
  sta_model #(.PHY(PHY)) sta_u (.mdio_wire(mdio_wire), .mdc(mdc), .sta_oe(sta_oe),
    .sta_o(sta_o));
  // Core clock, 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] r;
    sta_u.frame(1'b1, ra, d, r);
  endtask : wr
  // Read a direct register and compare
  task automatic rchk(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] r;
    sta_u.frame(1'b0, ra, 16'h0000, r);
    check(r, exp);
  endtask : rchk
  // Address set, then data function
  task automatic point(input logic [15:0] a, input logic [15:0] ctrl);
    wr(CR, 16'h001F);
    wr(DP, a);
    wr(CR, ctrl);
  endtask : point
  // Reset with mdc running so the link side clears too
  task automatic do_reset();
    fork
      sta_u.idle(12);
      begin
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
      end
    join
  endtask : do_reset
  task automatic t_reset_vals();
    rchk(CR, 16'h0000);
    rchk(5'h02, 16'h0000);
    wr(CR, 16'h001F);
    rchk(DP, 16'h0000);
    wr(DP, 16'h0170);
    wr(CR, 16'h401F);
    rchk(DP, 16'h0C10);
    check({15'h0000, clk_out_running}, 16'h0001);
    $display("test reset_vals done");
  endtask : t_reset_vals
  task automatic t_addr();
    wr(CR, 16'h001F);
    wr(DP, 16'h1234);
    wr(DP, 16'h0170);
    rchk(DP, 16'h0170);
    rchk(CR, 16'h001F);
    $display("test addr done");
  endtask : t_addr
  // Address left from before, steps skipped
  task automatic t_noinc();
    wr(CR, 16'h401F);
    rchk(DP, 16'h0C10);
    rchk(DP, 16'h0C10);
    wr(DP, 16'h0C50);
    wr(DP, 16'h0C10);
    rchk(DP, 16'h0C10);
    wr(CR, 16'h001F);
    rchk(DP, 16'h0170);
    $display("test noinc done");
  endtask : t_noinc
  task automatic t_inc_all();
    point(16'h016F, 16'h801F);
    rchk(DP, 16'h0000);
    rchk(DP, 16'h0C10);
    wr(DP, 16'h0C10);
    wr(CR, 16'h001F);
    rchk(DP, 16'h0172);
    $display("test inc_all done");
  endtask : t_inc_all
  task automatic t_inc_wr();
    point(16'h0170, 16'hC01F);
    rchk(DP, 16'h0C10);
    rchk(DP, 16'h0C10);
    wr(DP, 16'h0C10);
    wr(CR, 16'h001F);
    rchk(DP, 16'h0171);
    $display("test inc_wr done");
  endtask : t_inc_wr
  // Wrong device number: inert port, no increment
  task automatic t_bad_dev();
    point(16'h0170, 16'h801E);
    rchk(DP, 16'h0000);
    wr(DP, 16'h0C50);
    wr(CR, 16'h001F);
    rchk(DP, 16'h0170);
    wr(CR, 16'h401F);
    rchk(DP, 16'h0C10);
    $display("test bad_dev done");
  endtask : t_bad_dev
  // Pointer on the control and port numbers
  task automatic t_blocked();
    point(16'h000D, 16'h801F);
    wr(DP, 16'hFFFF);
    rchk(DP, 16'h0000);
    rchk(CR, 16'h801F);
    wr(CR, 16'h001F);
    rchk(DP, 16'h000F);
    $display("test blocked done");
  endtask : t_blocked
  // Frames for another address: no drive, nothing stored
  task automatic t_other_phy();
    logic [15:0] r;
    wr(CR, 16'h401F);
    sta_u.frame_to(PHY ^ 5'h01, 1'b1, CR, 16'h001F, r);
    rchk(CR, 16'h401F);
    sta_u.frame_to(PHY ^ 5'h01, 1'b0, CR, 16'h0000, r);
    check(r, 16'hFFFF);
    $display("test other_phy done");
  endtask : t_other_phy
  task automatic t_clk_off();
    point(16'h0170, 16'h401F);
    wr(DP, 16'h0C50);
    repeat (10) @(posedge clk);
    #1;
    check({14'h0000, clk_out_running, clk_out}, 16'h0000);
    rchk(DP, 16'h0C50);
    wr(DP, 16'h0C10);
    repeat (10) @(posedge clk);
    #1;
    check({15'h0000, clk_out_running}, 16'h0001);
    wr(DP, 16'h0C50); // Left stopped so the next reset must restart it
    repeat (10) @(posedge clk);
    #1;
    check({15'h0000, clk_out_running}, 16'h0000);
    $display("test clk_off done");
  endtask : t_clk_off
  // Verdict
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // Hang guard
  initial begin
    #1_000_000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
  // Main sequence, mid-run reset at the end
  initial begin
    sys_rst = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    do_reset();
    t_reset_vals();
    t_addr();
    t_noinc();
    t_inc_all();
    t_inc_wr();
    t_bad_dev();
    t_blocked();
    t_other_phy();
    t_clk_off();
    do_reset();
    t_reset_vals();
    complete_run();
  end
endmodule : mmd_indirect_register_access_tb
bind mmd_indirect_register_access mmd_checker #(.PHY_ADDRESS(PHY_ADDRESS)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .clk_out(clk_out), .clk_out_running(clk_out_running));
`default_nettype wire

/* sim/sta_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Station controller; mdc only runs inside frames and idle bursts
module sta_model #(
  parameter logic [4:0] PHY = 5'h03 // Device address used in frames
) (
  input wire logic mdio_wire, // Resolved data line
  output logic mdc, // Management clock
  output logic sta_oe, // Station drives line
  output logic sta_o // Station data
);
  initial begin
    mdc = 1'b0;
    sta_oe = 1'b0;
    sta_o = 1'b0;
  end
  // One bit time: set while low, sample just before the rise
  task automatic cyc(input logic oe, input logic b, output logic s);
    mdc = 1'b0;
    sta_oe = oe;
    sta_o = b;
    #24;
    s = mdio_wire;
    mdc = 1'b1;
    #24;
  endtask : cyc
  // Released bit times, so reset reaches the link logic
  task automatic idle(input int n);
    logic s;
    repeat (n) cyc(1'b0, 1'b0, s);
    mdc = 1'b0;
  endtask : idle
  // Whole frame to any address; line released in turnaround and data of reads
  task automatic frame_to(input logic [4:0] pa, input logic wr, input logic [4:0] ra,
                          input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'h1, wr ? 2'h1 : 2'h2, pa, ra};
    repeat (32) cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) cyc(1'b1, hdr[i], s);
    cyc(wr, 1'b1, s);
    cyc(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      cyc(wr, wd[i], s);
      rd[i] = s;
    end
    mdc = 1'b0;
    sta_oe = 1'b0;
  endtask : frame_to
  // Frame to the device under test
  task automatic frame(input logic wr, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    frame_to(PHY, wr, ra, wd, rd);
  endtask : frame
endmodule : sta_model
`default_nettype wire

/* src/level_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for one level into the clk_dst domain
module level_sync (
  input wire logic clk_dst, // Destination clock
  input wire logic d,       // Level from another domain
  output logic q            // Synchronised level
);

  logic meta_reg; // First stage, read only by the second

  // No reset: the chain flushes within two edges
  always_ff @(posedge clk_dst) begin
    meta_reg <= d;
    q <= meta_reg;
  end

endmodule : level_sync

`default_nettype wire

/* src/mmd_indirect_register_access.sv */
`timescale 1ns/1ps
`default_nettype none

module mmd_indirect_register_access #(
  parameter logic [4:0] PHY_ADDRESS = 5'h00 // Management address this device answers
) (
  input wire logic clk,          // Core clock, 40 MHz
  input wire logic sys_rst,      // Synchronous reset, active high
  input wire logic mdc,          // Management clock from the controller
  input wire logic mdio_in,      // Management data pin, input side
  output logic mdio_out,         // Management data pin, output side
  output logic mdio_oe,          // High while this device drives the data pin
  output logic clk_out,          // Clock output pin
  output logic clk_out_running   // High while the clock output toggles
);

  // ---------------------------------------------------------------
  // Link side, clocked by mdc
  // ---------------------------------------------------------------

  // Frame sequencing states
  typedef enum logic [2:0] {
    ST_PREAMBLE,
    ST_START,
    ST_HEADER,
    ST_TURN,
    ST_READ,
    ST_WRITE
  } frame_state_t;

  logic link_rst; // Reset seen in the mdc domain
  frame_state_t state_reg; // Current frame phase
  logic [5:0] ones_reg; // Run of preamble ones, saturating
  logic [4:0] bit_reg; // Bit index within the current phase
  logic [11:0] hdr_reg; // Opcode, device address, register number
  logic [15:0] shift_reg; // Read data out or write data in
  logic is_read_reg; // Frame in progress is a read
  logic [4:0] acc_reg_reg; // Register number of the frame
  logic mdio_out_reg; // Pin output flop
  logic mdio_oe_reg; // Pin enable flop
  logic req_toggle_reg; // Flips once per finished access
  mmd_pkg::mgmt_access_t req_reg; // Access handed to the core

  logic [11:0] hdr_next; // Header including the bit now on the pin
  logic header_done; // Last header bit sampled this edge
  logic frame_for_us; // Address matches and opcode is legal
  logic write_done; // Last write data bit sampled this edge
  logic read_done; // Read data fully shifted out this edge
  logic [15:0] write_word; // Write data including the current bit
  mmd_pkg::read_view_t view_reg; // Published by the core side

  // Reset must reach mdc, so the controller keeps mdc running in reset
  level_sync u_link_rst_sync (
    .clk_dst(mdc),
    .d(sys_rst),
    .q(link_rst)
  );

  // Frame decode terms
  always_comb begin
    hdr_next = {hdr_reg[10:0], mdio_in};
    header_done = (state_reg == ST_HEADER) && (bit_reg == mmd_pkg::HEADER_LAST_BIT);
    frame_for_us = (hdr_next[9:5] == PHY_ADDRESS) &&
                   ((hdr_next[11:10] == mmd_pkg::OP_READ) ||
                    (hdr_next[11:10] == mmd_pkg::OP_WRITE));
    write_word = {shift_reg[14:0], mdio_in};
    write_done = (state_reg == ST_WRITE) && (bit_reg == mmd_pkg::DATA_LAST_BIT);
    read_done = (state_reg == ST_READ) && (bit_reg == mmd_pkg::DATA_BITS);
  end

  // Frame sequencer: preamble, start, header, turnaround, data
  always_ff @(posedge mdc) begin
    if (link_rst) begin
      state_reg <= ST_PREAMBLE;
      ones_reg <= 6'h00;
      bit_reg <= 5'h00;
      hdr_reg <= 12'h000;
      shift_reg <= 16'h0000;
      is_read_reg <= 1'b0;
      acc_reg_reg <= 5'h00;
    end else begin
      case (state_reg)
        ST_PREAMBLE: begin
          // A zero after a full preamble is the first start bit
          if (mdio_in) begin
            if (ones_reg != mmd_pkg::PREAMBLE_ONES) begin
              ones_reg <= ones_reg + 6'h01;
            end
          end else begin
            if (ones_reg == mmd_pkg::PREAMBLE_ONES) begin
              state_reg <= ST_START;
            end
            ones_reg <= 6'h00;
          end
        end
        ST_START: begin
          // Second start bit must be one, else hunt again
          bit_reg <= 5'h00;
          state_reg <= mdio_in ? ST_HEADER : ST_PREAMBLE;
        end
        ST_HEADER: begin
          hdr_reg <= hdr_next;
          bit_reg <= bit_reg + 5'h01;
          if (header_done) begin
            // Frames for other addresses are dropped; a fresh preamble follows
            bit_reg <= 5'h00;
            is_read_reg <= (hdr_next[11:10] == mmd_pkg::OP_READ);
            acc_reg_reg <= hdr_next[4:0];
            state_reg <= frame_for_us ? ST_TURN : ST_PREAMBLE;
          end
        end
        ST_TURN: begin
          if (is_read_reg) begin
            // Pick the word now; for which two registers exist
            state_reg <= ST_READ;
            bit_reg <= 5'h00;
            if (acc_reg_reg == mmd_pkg::REG_ACCESS_CONTROL) begin
              shift_reg <= view_reg.access_control;
            end else if (acc_reg_reg == mmd_pkg::REG_DATA_PORT) begin
              shift_reg <= view_reg.data_port;
            end else begin
              // Other direct registers are outside this block
              shift_reg <= 16'h0000;
            end
          end else if (bit_reg == mmd_pkg::TURN_LAST_BIT) begin
            state_reg <= ST_WRITE;
            bit_reg <= 5'h00;
          end else begin
            bit_reg <= bit_reg + 5'h01;
          end
        end
        ST_READ: begin
          // Most significant bit leaves first
          if (read_done) begin
            state_reg <= ST_PREAMBLE;
            ones_reg <= 6'h00;
          end else begin
            shift_reg <= {shift_reg[14:0], 1'b0};
            bit_reg <= bit_reg + 5'h01;
          end
        end
        ST_WRITE: begin
          shift_reg <= write_word;
          bit_reg <= bit_reg + 5'h01;
          if (write_done) begin
            state_reg <= ST_PREAMBLE;
            ones_reg <= 6'h00;
          end
        end
        default: begin
          state_reg <= ST_PREAMBLE;
        end
      endcase
    end
  end

  // Pin drive: released except for turnaround zero and read data
  always_ff @(posedge mdc) begin
    if (link_rst) begin
      mdio_out_reg <= 1'b0;
      mdio_oe_reg <= 1'b0;
    end else if ((state_reg == ST_TURN) && is_read_reg) begin
      // Second turnaround bit driven low
      mdio_out_reg <= 1'b0;
      mdio_oe_reg <= 1'b1;
    end else if ((state_reg == ST_READ) && !read_done) begin
      mdio_out_reg <= shift_reg[15];
      mdio_oe_reg <= 1'b1;
    end else begin
      mdio_out_reg <= 1'b0;
      mdio_oe_reg <= 1'b0;
    end
  end

  assign mdio_out = mdio_out_reg;
  assign mdio_oe = mdio_oe_reg;

  // Hand each finished access to the core by a toggle
  always_ff @(posedge mdc) begin
    if (link_rst) begin
      req_toggle_reg <= 1'b0;
      req_reg <= '0;
    end else if (write_done) begin
      // Word is held until the next frame ends, far past the core's sampling
      req_reg <= '{write: 1'b1, reg_addr: acc_reg_reg, wdata: write_word};
      req_toggle_reg <= ~req_toggle_reg;
    end else if (read_done) begin
      // Reads are reported too, as they may move the address
      req_reg <= '{write: 1'b0, reg_addr: acc_reg_reg, wdata: 16'h0000};
      req_toggle_reg <= ~req_toggle_reg;
    end
  end

  // ---------------------------------------------------------------
  // Core side, clocked by clk
  // ---------------------------------------------------------------

  logic req_toggle_sync; // Toggle after two flops
  logic req_toggle_seen_reg; // Last toggle level acted upon
  logic access_strobe; // One-cycle pulse per finished access
  logic [15:0] access_control_reg; // Function and device number
  logic [15:0] ext_addr_reg; // Extended address pointer
  logic [15:0] clock_output_config_reg; // Extended register at clock_output_config
  logic clk_out_reg; // Clock output flop
  logic clk_out_running_reg; // Clock output enable as shown
  logic [1:0] func; // Current access function
  logic device_ok; // Device number selects the general set
  logic port_hit; // Data port access that is honoured
  logic ext_blocked; // Pointer names one of the two direct-only registers
  logic inc_now; // Post-increment for this access
  logic [15:0] ext_read; // Extended register under the pointer

  level_sync u_req_sync (
    .clk_dst(clk),
    .d(req_toggle_reg),
    .q(req_toggle_sync)
  );

  // Edge of the synchronised toggle marks a new access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_toggle_seen_reg <= 1'b0;
    end else begin
      req_toggle_seen_reg <= req_toggle_sync;
    end
  end

  // Access decode
  always_comb begin
    access_strobe = req_toggle_sync ^ req_toggle_seen_reg;
    func = access_control_reg[mmd_pkg::FUNC_MSB:mmd_pkg::FUNC_LSB];
    device_ok = (access_control_reg[mmd_pkg::DEVNUM_MSB:mmd_pkg::DEVNUM_LSB] ==
                 mmd_pkg::GENERAL_DEVICE_NUMBER);
    port_hit = access_strobe && device_ok &&
               (req_reg.reg_addr == mmd_pkg::REG_DATA_PORT);
    ext_blocked = (ext_addr_reg == mmd_pkg::EXT_BLOCKED_CONTROL) ||
                  (ext_addr_reg == mmd_pkg::EXT_BLOCKED_PORT);
    // Function 10 moves on every access, 11 on writes only
    inc_now = (func == mmd_pkg::FUNC_DATA_INC_ALL) ||
              ((func == mmd_pkg::FUNC_DATA_INC_WRITE) && req_reg.write);
    if (!ext_blocked && (ext_addr_reg == mmd_pkg::CLOCK_OUTPUT_CONFIG_ADDR)) begin
      ext_read = clock_output_config_reg;
    end else begin
      // Unimplemented extended registers read as zero
      ext_read = 16'h0000;
    end
  end

  // Access-control register, written only by direct frames
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      access_control_reg <= mmd_pkg::ACCESS_CONTROL_RESET;
    end else if (access_strobe && req_reg.write &&
                 (req_reg.reg_addr == mmd_pkg::REG_ACCESS_CONTROL)) begin
      access_control_reg <= req_reg.wdata;
    end
  end

  // Extended address pointer: load in function 00, step in 10/11
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_addr_reg <= mmd_pkg::EXT_ADDR_RESET;
    end else if (port_hit) begin
      if (func == mmd_pkg::FUNC_ADDRESS) begin
        if (req_reg.write) begin
          ext_addr_reg <= req_reg.wdata;
        end
      end else if (inc_now) begin
        // Wraps at the top of the space
        ext_addr_reg <= ext_addr_reg + 16'h0001;
      end
      // Function 01 leaves the pointer alone
    end
  end

  // Clock output configuration, the one implemented extended register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clock_output_config_reg <= mmd_pkg::CLOCK_OUTPUT_CONFIG_RESET;
    end else if (port_hit && req_reg.write && (func != mmd_pkg::FUNC_ADDRESS) &&
                 !ext_blocked &&
                 (ext_addr_reg == mmd_pkg::CLOCK_OUTPUT_CONFIG_ADDR)) begin
      clock_output_config_reg <= req_reg.wdata;
    end
  end

  // Publish read values for the link side every cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      view_reg <= '0;
    end else begin
      view_reg.access_control <= access_control_reg;
      if (!device_ok) begin
        // Wrong device number: data port reads as zero
        view_reg.data_port <= 16'h0000;
      end else if (func == mmd_pkg::FUNC_ADDRESS) begin
        view_reg.data_port <= ext_addr_reg;
      end else begin
        view_reg.data_port <= ext_read;
      end
    end
  end
  // The view changes only a few clk after an access ends, well inside
  // the next frame's preamble, so the link samples a settled word.

  // Clock output: clk divided by two while the off bit is clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_out_running_reg <= 1'b1;
      clk_out_reg <= 1'b0;
    end else begin
      clk_out_running_reg <= !clock_output_config_reg[mmd_pkg::CLOCK_OUTPUT_OFF_BIT];
      // Parked low when stopped, so no runt pulse on restart
      clk_out_reg <= clk_out_running_reg ? ~clk_out_reg : 1'b0;
    end
  end

  assign clk_out = clk_out_reg;
  assign clk_out_running = clk_out_running_reg;

endmodule : mmd_indirect_register_access

`default_nettype wire
